/* File: spss_pkg.sv */
// Purpose: Shared constants for the serial port host controller.
// Assumes: 40 MHz system clock; byte-addressed Avalon-MM register window.
// Notes: Device-side register layout is kept here as a map only.
package spss_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCK_PERIOD_NS = 200;
  localparam int I2C_BIT_PERIOD_NS = 10000;
  localparam int SPI_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int I2C_QUARTER_CYC = I2C_BIT_PERIOD_NS / (4 * CLK_PERIOD_NS);

  // Host register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_TX = 5'h04;
  localparam logic [4:0] REG_CMD = 5'h08;
  localparam logic [4:0] REG_STAT = 5'h0c;
  localparam logic [4:0] REG_RX = 5'h10;

  // Control fields
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  localparam int CTRL_LINK_I2C = 0;
  localparam int CTRL_IDLE_HIGH = 1;
  localparam int CTRL_LATE_PHASE = 2;
  localparam int CTRL_KEEP_SELECT = 3;
  localparam int CTRL_WAKE_ALLOW = 4;
  localparam int CTRL_DEV_SLEEP = 5;

  // Status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_RX_FULL = 1;
  localparam int STAT_NACK = 2;
  localparam int STAT_ARB_LOST = 3;
  localparam int STAT_COLLISION = 4;

  // Command codes
  localparam logic [2:0] CMD_SPI_BYTE = 3'h1;
  localparam logic [2:0] CMD_SPI_DESELECT = 3'h2;
  localparam logic [2:0] CMD_I2C_START = 3'h3;
  localparam logic [2:0] CMD_I2C_WRITE = 3'h4;
  localparam logic [2:0] CMD_I2C_READ_ACK = 3'h5;
  localparam logic [2:0] CMD_I2C_READ_NACK = 3'h6;
  localparam logic [2:0] CMD_I2C_STOP = 3'h7;

  // Device map: mode field value for slave with select honoured
  localparam logic [3:0] DEV_MODE_SLAVE_SELECT = 4'h4;
  localparam int DEV_CTL1_PORT_ENABLE_BIT = 5;
  localparam int DEV_CTL1_CLOCK_IDLE_POLARITY = 4;
  localparam int DEV_STAT_INPUT_SAMPLE_PHASE = 7;
  localparam int DEV_STAT_BUFFER_FULL_FLAG = 0;
  localparam int DEV_CTL1_WRITE_COLLISION_FLAG = 7;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SPI_SEL,
    ST_SPI_BITS,
    ST_SPI_DESEL,
    ST_I2C_START,
    ST_I2C_BIT,
    ST_I2C_STOP
  } spss_state_t;

endpackage : spss_pkg

/* File: spss_sync.sv */
// Purpose: Two-flop synchroniser for one asynchronous level.
// Assumes: Input comes from a pin outside the clock domain.
// Notes: Only the second flop is visible to logic.
module spss_sync
  import spss_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic din, // Asynchronous level
  output logic dout // Synchronised level
);

  typedef struct packed {
    logic meta;
    logic out;
  } spss_sync_t;

  spss_sync_t cur;
  spss_sync_t next_cur;

  always_comb
  begin
    next_cur.meta = din;
    next_cur.out = cur.meta;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign dout = cur.out;

endmodule // spss_sync

/* File: spss_tick.sv */
// Purpose: Divider producing a one-cycle tick every DIV clocks.
// Assumes: clear restarts a full period.
// Notes: Paces both the SPI half bit and the two-wire quarter bit.
module spss_tick
  import spss_pkg::*;
#(
  parameter int DIV = 4
)
(
  input wire logic clock, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic clear, // Restart count
  output logic tick // One-cycle pulse
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] count;
  } spss_tick_t;

  spss_tick_t cur;
  spss_tick_t next_cur;

  always_comb
  begin
    next_cur = cur;
    if (clear || cur.count == LAST)
    begin
      next_cur.count = '0;
    end
    else
    begin
      next_cur.count = cur.count + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign tick = !clear && cur.count == LAST;

endmodule // spss_tick

/* File: spss_host.sv */
// Purpose: Host controller driving a serial port unit as SPI slave and as two-wire bus peer.
// Assumes: Software reaches the host over Avalon-MM; device pins are asynchronous.
// Notes: The host makes SCK and SCL itself by dividing the system clock.
// Operation
// - Slave-select control must be used when the clock edge bit is set.
// - Sample phase must stay cleared while the port is an SPI slave.
// - Disable port event enable before sleep if no wake wanted; the host drops it in the same cycle as sleep_request rises.
// - Two-wire lines are open drain; low is zero, released is one.
// - Start is SDA falling while SCL high.
// - Stop is SDA rising while SCL high.
// - SDA data changes only while SCL low.
// - Master opens with start, address, then direction bit, one for read.
// - Address and data bytes go most significant bit first.
// - Receiver acknowledges each byte by holding SDA low.
// - Addressed slave acknowledges; roles stay complementary after.
// - Receiving master ends with stop in place of last acknowledge.
// - Master may repeat start instead of stop or last acknowledge.
// - Released line read low means stretching on SCL, lost arbitration on SDA.
// - SCK must rest at the idle polarity before slave mode is enabled.
module spss_host
  import spss_pkg::*;
#(
  parameter int SPI_HALF = SPI_HALF_CYC,
  parameter int I2C_QUARTER = I2C_QUARTER_CYC
)
(
  input wire logic clock, // System clock, 40 MHz
  input wire logic rst, // Async reset, active high
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic sck, // SPI clock to device
  output logic select_n, // Slave select, active low
  output logic mosi, // Data to device SDI
  input wire logic miso, // Data from device SDO
  input wire logic scl_i, // Two-wire clock level
  output logic scl_o, // Two-wire clock drive value
  output logic scl_oe, // Two-wire clock pull low
  input wire logic sda_i, // Two-wire data level
  output logic sda_o, // Two-wire data drive value
  output logic sda_oe, // Two-wire data pull low
  output logic port_event_enable, // Device may wake on port event
  output logic sleep_request // Ask device to sleep
);

  typedef struct packed {
    spss_state_t state;
    logic ack;
    logic [31:0] rdata;
    logic [CTRL_W-1:0] ctrl;
    logic [7:0] tx;
    logic [7:0] rx;
    logic rx_full;
    logic nack;
    logic arb;
    logic coll;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [3:0] half;
    logic [1:0] quarter;
    logic [3:0] bit_ix;
    logic rd_op;
    logic ack_low;
    logic sck;
    logic sel_n;
    logic mosi;
    logic scl_low;
    logic sda_low;
  } spss_host_t;

  spss_host_t cur;
  spss_host_t next_cur;
  logic miso_s;
  logic scl_s;
  logic sda_s;
  logic spi_tick;
  logic i2c_tick;
  logic busy;
  logic cpha;

  // Device SDO floats outside a frame; only the synchronised copy is used
  spss_sync u_sync_miso (.clock(clock), .rst(rst), .din(miso), .dout(miso_s));
  spss_sync u_sync_scl (.clock(clock), .rst(rst), .din(scl_i), .dout(scl_s));
  spss_sync u_sync_sda (.clock(clock), .rst(rst), .din(sda_i), .dout(sda_s));

  spss_tick #(.DIV(SPI_HALF)) u_spi_tick (
    .clock(clock),
    .rst(rst),
    .clear(cur.state == ST_IDLE),
    .tick(spi_tick)
  );

  spss_tick #(.DIV(I2C_QUARTER)) u_i2c_tick (
    .clock(clock),
    .rst(rst),
    .clear(cur.state == ST_IDLE),
    .tick(i2c_tick)
  );

  assign busy = cur.state != ST_IDLE;
  assign cpha = cur.ctrl[CTRL_LATE_PHASE];

  always_comb
  begin
    next_cur = cur;

    // Bus slave: one wait cycle, answer registered
    if (cur.ack)
    begin
      next_cur.ack = 1'b0;
    end
    else if (avs_read || avs_write)
    begin
      next_cur.ack = 1'b1;
      unique case (avs_address)
        REG_CTRL: next_cur.rdata = {{(32-CTRL_W){1'b0}}, cur.ctrl};
        REG_TX: next_cur.rdata = {24'h000000, cur.tx};
        REG_STAT: next_cur.rdata = {27'h0000000, cur.coll, cur.arb, cur.nack, cur.rx_full, busy};
        REG_RX: next_cur.rdata = {24'h000000, cur.rx};
        default: next_cur.rdata = 32'h00000000;
      endcase
    end

    if (cur.ack && avs_read && avs_address == REG_RX)
    begin
      next_cur.rx_full = 1'b0;
    end

    if (cur.ack && avs_write)
    begin
      unique case (avs_address)
        REG_CTRL: next_cur.ctrl = avs_writedata[CTRL_W-1:0];
        REG_TX:
        begin
          // Writes during a transfer are dropped, as the device does
          if (busy)
            next_cur.coll = 1'b1;
          else
            next_cur.tx = avs_writedata[7:0];
        end
        REG_STAT:
        begin
          if (avs_writedata[STAT_NACK])
            next_cur.nack = 1'b0;
          if (avs_writedata[STAT_ARB_LOST])
            next_cur.arb = 1'b0;
          if (avs_writedata[STAT_COLLISION])
            next_cur.coll = 1'b0;
        end
        REG_CMD:
        begin
          if (busy)
          begin
            next_cur.coll = 1'b1;
          end
          else
          begin
            unique case (avs_writedata[2:0])
              CMD_SPI_BYTE:
              begin
                // Select falls first so the device starts a fresh frame
                next_cur.state = ST_SPI_SEL;
                next_cur.sel_n = 1'b0;
                next_cur.half = 4'h0;
                next_cur.tx_sh = cur.tx;
                if (!cpha)
                begin
                  next_cur.mosi = cur.tx[7];
                  next_cur.tx_sh = {cur.tx[6:0], 1'b0};
                end
              end
              CMD_SPI_DESELECT: next_cur.state = ST_SPI_DESEL;
              CMD_I2C_START:
              begin
                next_cur.state = ST_I2C_START;
                next_cur.quarter = 2'h0;
              end
              CMD_I2C_STOP:
              begin
                next_cur.state = ST_I2C_STOP;
                next_cur.quarter = 2'h0;
              end
              CMD_I2C_WRITE, CMD_I2C_READ_ACK, CMD_I2C_READ_NACK:
              begin
                // Address byte is tx with the direction bit in bit 0
                next_cur.state = ST_I2C_BIT;
                next_cur.quarter = 2'h0;
                next_cur.bit_ix = 4'h0;
                next_cur.tx_sh = cur.tx;
                next_cur.rd_op = avs_writedata[2:0] != CMD_I2C_WRITE;
                next_cur.ack_low = avs_writedata[2:0] == CMD_I2C_READ_ACK;
              end
              default: next_cur.coll = 1'b1;
            endcase
          end
        end
        default: ;
      endcase
    end

    unique case (cur.state)
      ST_IDLE:
      begin
        // SCK rests at the chosen idle level outside frames
        next_cur.sck = cur.ctrl[CTRL_IDLE_HIGH];
      end
      ST_SPI_SEL:
      begin
        if (spi_tick)
          next_cur.state = ST_SPI_BITS;
      end
      ST_SPI_BITS:
      begin
        if (spi_tick)
        begin
          next_cur.half = cur.half + 4'h1;
          if (!cur.half[0])
          begin
            next_cur.sck = !cur.ctrl[CTRL_IDLE_HIGH];
            // Data launched half a bit ahead, so sampling never sits on an edge
            if (cpha)
            begin
              next_cur.mosi = cur.tx_sh[7];
              next_cur.tx_sh = {cur.tx_sh[6:0], 1'b0};
            end
            else
            begin
              next_cur.rx_sh = {cur.rx_sh[6:0], miso_s};
            end
          end
          else
          begin
            next_cur.sck = cur.ctrl[CTRL_IDLE_HIGH];
            if (cpha)
              next_cur.rx_sh = {cur.rx_sh[6:0], miso_s};
            else if (cur.half != 4'hf)
            begin
              next_cur.mosi = cur.tx_sh[7];
              next_cur.tx_sh = {cur.tx_sh[6:0], 1'b0};
            end
            if (cur.half == 4'hf)
            begin
              // Eighth bit done: device has buffered its byte too
              next_cur.rx = cpha ? {cur.rx_sh[6:0], miso_s} : cur.rx_sh;
              next_cur.rx_full = 1'b1;
              next_cur.state = cur.ctrl[CTRL_KEEP_SELECT] ? ST_IDLE : ST_SPI_DESEL;
            end
          end
        end
      end
      ST_SPI_DESEL:
      begin
        // Select high resets the device bit counter and floats SDO
        if (spi_tick)
        begin
          next_cur.sel_n = 1'b1;
          next_cur.state = ST_IDLE;
        end
      end
      ST_I2C_START:
      begin
        if (i2c_tick)
        begin
          unique case (cur.quarter)
            2'h0: next_cur.sda_low = 1'b0;
            2'h1: next_cur.scl_low = 1'b0;
            2'h2: if (scl_s) next_cur.sda_low = 1'b1;
            2'h3:
            begin
              next_cur.scl_low = 1'b1;
              next_cur.state = ST_IDLE;
            end
          endcase
          if (cur.quarter != 2'h2 || scl_s)
            next_cur.quarter = cur.quarter + 2'h1;
        end
      end
      ST_I2C_STOP:
      begin
        if (i2c_tick)
        begin
          unique case (cur.quarter)
            2'h0: next_cur.scl_low = 1'b1;
            2'h1: next_cur.sda_low = 1'b1;
            2'h2: next_cur.scl_low = 1'b0;
            2'h3:
            begin
              if (scl_s)
              begin
                next_cur.sda_low = 1'b0;
                next_cur.state = ST_IDLE;
              end
            end
          endcase
          if (cur.quarter != 2'h3)
            next_cur.quarter = cur.quarter + 2'h1;
        end
      end
      ST_I2C_BIT:
      begin
        if (i2c_tick)
        begin
          unique case (cur.quarter)
            2'h0:
            begin
              // SDA moves only with SCL held low
              if (cur.bit_ix == 4'h8)
                next_cur.sda_low = cur.rd_op && cur.ack_low;
              else if (cur.rd_op)
                next_cur.sda_low = 1'b0;
              else
              begin
                next_cur.sda_low = !cur.tx_sh[7];
                next_cur.tx_sh = {cur.tx_sh[6:0], 1'b0};
              end
              next_cur.quarter = 2'h1;
            end
            2'h1:
            begin
              next_cur.scl_low = 1'b0;
              next_cur.quarter = 2'h2;
            end
            2'h2:
            begin
              // Released SCL still low: slave is stretching, wait
              if (scl_s)
                next_cur.quarter = 2'h3;
            end
            2'h3:
            begin
              next_cur.scl_low = 1'b1;
              next_cur.quarter = 2'h0;
              next_cur.bit_ix = cur.bit_ix + 4'h1;
              if (cur.bit_ix == 4'h8)
              begin
                next_cur.state = ST_IDLE;
                if (!cur.rd_op)
                  next_cur.nack = sda_s;
                else
                begin
                  next_cur.rx = cur.rx_sh;
                  next_cur.rx_full = 1'b1;
                end
              end
              else if (cur.rd_op)
                next_cur.rx_sh = {cur.rx_sh[6:0], sda_s};
              else if (!cur.sda_low && !sda_s)
              begin
                // Another master pulled our released one low
                next_cur.arb = 1'b1;
                next_cur.scl_low = 1'b0;
                next_cur.state = ST_IDLE;
              end
            end
          endcase
        end
      end
      default: next_cur.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cur <= '0;
      cur.state <= ST_IDLE;
      cur.ctrl <= CTRL_RESET;
      cur.sel_n <= 1'b1;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign avs_readdata = cur.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !cur.ack;
  assign sck = cur.sck;
  assign select_n = cur.sel_n;
  assign mosi = cur.mosi;
  // Lines are only ever pulled low or released
  assign scl_o = 1'b0;
  assign scl_oe = cur.scl_low;
  assign sda_o = 1'b0;
  assign sda_oe = cur.sda_low;
  // Port event enable stays on while awake; during sleep only when software allows wake
  assign port_event_enable = cur.ctrl[CTRL_WAKE_ALLOW] || !cur.ctrl[CTRL_DEV_SLEEP];
  assign sleep_request = cur.ctrl[CTRL_DEV_SLEEP];

endmodule // spss_host

/* File: spss_host_sva.sv */
// Purpose: Port-level checks for the serial port host.
// Assumes: SCK idle low, early data phase, SPI_HALF of 4.
// Notes: Start and stop checks compare drive enables with the raw bus clock level.
module spss_host_sva
#(
  parameter int SPI_HALF = 4
)
(
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic avs_waitrequest, // Stall
  input wire logic sck, // SPI clock
  input wire logic select_n, // Select
  input wire logic mosi, // SPI data
  input wire logic scl_i, // Bus clock
  input wire logic scl_oe, // Clock pull
  input wire logic sda_o, // Data value
  input wire logic sda_oe, // Data pull
  input wire logic port_event_enable, // Wake gate
  input wire logic sleep_request // Sleep
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence high_half;
    sck [*4] ##1 !sck;
  endsequence
  sequence low_half;
    !sck [*4];
  endsequence
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  sck_idle_a: assert property (select_n && $past(select_n) |-> $stable(sck))
    else $error("clock moved outside frame");
  // Select setup is two half periods: one in the select state, one before the first edge
  sel_setup_a: assert property ($fell(select_n) |-> low_half ##1 low_half ##1 sck)
    else $error("select setup wrong");
  sck_high_a: assert property ($rose(sck) |-> high_half)
    else $error("clock high half wrong");
  sel_rise_a: assert property ($rose(select_n) |-> !sck && !$past(sck, SPI_HALF))
    else $error("select rose mid pulse");
  // With select held between bytes the next first bit is launched while the clock idles low
  mosi_edge_a: assert property ($changed(mosi) && !select_n |-> !sck)
    else $error("data moved with clock high");
  start_cond_a: assert property ($rose(sda_oe) && !scl_oe && !$past(scl_oe) |-> scl_i)
    else $error("start without clock high");
  stop_cond_a: assert property ($fell(sda_oe) && !scl_oe && !$past(scl_oe) |-> scl_i)
    else $error("stop without clock high");
  data_low_a: assert property ($changed(sda_oe) && $past(scl_oe) |-> scl_oe || !sda_oe)
    else $error("data pulled with clock high");
  drain_only_a: assert property (!sda_o)
    else $error("data driven high");
  wake_gate_a: assert property (!sleep_request |-> port_event_enable)
    else $error("wake gated while awake");
endmodule // spss_host_sva

bind spss_host spss_host_sva #(.SPI_HALF(SPI_HALF)) u_host_sva (.clock(clock), .rst(rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .sck(sck),
  .select_n(select_n), .mosi(mosi), .scl_i(scl_i), .scl_oe(scl_oe), .sda_o(sda_o),
  .sda_oe(sda_oe), .port_event_enable(port_event_enable), .sleep_request(sleep_request));

/* File: spss_dev_model.sv */
// Purpose: Behavioural serial port unit: SPI slave with select, two-wire slave.
// Assumes: SCK idle low, early phase; bus lines resolved by the bench.
// Notes: Released SDO shows the inverse of shift register bit 7, as no pull is fitted.
module spss_dev_model
  import spss_pkg::*;
#(
  parameter logic [3:0] MODE = DEV_MODE_SLAVE_SELECT,
  parameter logic [6:0] ADDR = 7'h2a,
  parameter logic [7:0] RD_BYTE = 8'ha5
)
(
  input wire logic sck, // SPI clock
  input wire logic select_n, // Select
  input wire logic mosi, // Data in
  output logic miso, // Data out
  input wire logic [7:0] spi_tx, // Frame load
  output logic [7:0] spi_rx, // Last byte
  output logic [7:0] ev_cnt, // Port events
  input wire logic scl, // Bus clock
  input wire logic sda, // Bus data
  output logic sda_pull, // Pull data
  output logic [7:0] i2c_rx, // Last written
  output logic i2c_act // In message
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic inb = 1'b0;
  logic [7:0] ish = 8'h00;
  logic [3:0] ib = 4'h0;
  logic first = 1'b0;
  logic rdm = 1'b0;
  wire sel = (MODE == DEV_MODE_SLAVE_SELECT) && !select_n;
  assign miso = sel ? sh[7] : !sh[7];
  initial
  begin
    {spi_rx, ev_cnt, i2c_rx} = 24'h0;
    {sda_pull, i2c_act} = 2'b00;
  end
  always @(negedge select_n)
  begin
    cnt = 4'h0;
    sh = spi_tx;
  end
  always @(posedge select_n)
    cnt = 4'h0;
  always @(posedge sck)
    if (sel)
      inb = mosi;
  always @(negedge sck)
    if (sel)
    begin
      sh = {sh[6:0], inb};
      cnt = cnt + 4'h1;
      if (cnt == 4'h8)
      begin
        spi_rx = sh;
        ev_cnt = ev_cnt + 8'h01;
        cnt = 4'h0;
      end
    end
  always @(negedge sda)
    if (scl)
    begin
      i2c_act = 1'b1;
      ib = 4'hf;
      first = 1'b1;
      rdm = 1'b0;
    end
  always @(posedge sda)
    if (scl)
    begin
      i2c_act = 1'b0;
      sda_pull = 1'b0;
    end
  always @(posedge scl)
    if (i2c_act && ib < 4'h8)
      ish = {ish[6:0], sda};
  always @(negedge scl)
    if (i2c_act)
    begin
      ib = ib + 4'h1;
      if (ib == 4'h8 && first)
      begin
        rdm = ish[0];
        i2c_act = (ish[7:1] == ADDR);
        sda_pull = i2c_act;
      end
      else if (ib == 4'h8)
      begin
        if (!rdm)
          i2c_rx = ish;
        sda_pull = !rdm;
      end
      else if (ib == 4'h9)
      begin
        first = 1'b0;
        ib = 4'h0;
        sda_pull = rdm && !RD_BYTE[7];
      end
      else if (rdm && !first)
        sda_pull = !RD_BYTE[4'h7 - ib];
    end
endmodule // spss_dev_model

/* File: spss_host_tb_top.sv */
// Purpose: Self-checking bench for the serial port host.
// Assumes: Short two-wire quarter of 8 clocks keeps the run brief.
// Notes: SDA is the wired-AND of the host pull and the model's pull; SCL follows the host pull alone.
module spss_host_tb_top
  import spss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, sck, select_n, mosi, miso, scl_o, scl_oe, sda_o, sda_oe;
  logic port_event_enable, sleep_request, sda_pull, i2c_act;
  logic [7:0] dev_tx = 8'h00;
  logic [7:0] spi_rx, ev_cnt, i2c_rx;
  wire scl_line = !scl_oe;
  wire sda_line = !(sda_oe || sda_pull);
  int n_fail = 0;
  int n_compared = 0;
  always #12.5 clock = !clock;
  spss_host #(.SPI_HALF(4), .I2C_QUARTER(8)) dut (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sck(sck), .select_n(select_n),
    .mosi(mosi), .miso(miso), .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .port_event_enable(port_event_enable), .sleep_request(sleep_request));
  spss_dev_model dev (.sck(sck), .select_n(select_n), .mosi(mosi), .miso(miso), .spi_tx(dev_tx),
    .spi_rx(spi_rx), .ev_cnt(ev_cnt), .scl(scl_line), .sda(sda_line), .sda_pull(sda_pull),
    .i2c_rx(i2c_rx), .i2c_act(i2c_act));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Request held until waitrequest is seen low; one idle edge keeps requests apart
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge clock);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk_rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  // A stuck busy flag is left to the watchdog
  task automatic wait_idle;
    logic [31:0] q;
    bus(1'b0, REG_STAT, 32'h0, q);
    while (q[STAT_BUSY] !== 1'b0)
    begin
      bus(1'b0, REG_STAT, 32'h0, q);
    end
  endtask
  task automatic cmd(input logic [2:0] c, input logic [7:0] tx);
    wr(REG_TX, {24'h0, tx});
    wr(REG_CMD, {29'h0, c});
    wait_idle;
  endtask
  task automatic t_regs;
    chk_rd(REG_STAT, 32'h0);
    wr(REG_CTRL, 32'h39);
    chk_rd(REG_CTRL, 32'h39);
    chk_rd(5'h14, 32'h0);
    check({30'h0, sleep_request, port_event_enable}, 32'h3);
    wr(REG_CTRL, 32'h20);
    check({30'h0, sleep_request, port_event_enable}, 32'h2);
    wr(REG_CTRL, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_spi(input logic [7:0] tx, input logic [7:0] dx, input logic slp);
    logic [7:0] ev0;
    ev0 = ev_cnt;
    dev_tx <= dx;
    wr(REG_CTRL, slp ? 32'h30 : 32'h00);
    wr(REG_TX, {24'h0, tx});
    wr(REG_CMD, {29'h0, CMD_SPI_BYTE});
    wr(REG_CMD, {29'h0, CMD_SPI_BYTE});
    wait_idle;
    check({24'h0, spi_rx}, {24'h0, tx});
    check({24'h0, ev_cnt}, {24'h0, ev0 + 8'h01});
    check({31'h0, port_event_enable}, 32'h1);
    chk_rd(REG_RX, {24'h0, dx});
    chk_rd(REG_STAT, 32'h10);
    wr(REG_STAT, 32'h1c);
    chk_rd(REG_STAT, 32'h0);
    $display("test spi byte %h done", tx);
  endtask
  task automatic t_keep(input logic [7:0] a, input logic [7:0] b);
    wr(REG_CTRL, 32'h08);
    cmd(CMD_SPI_BYTE, a);
    check({31'h0, select_n}, 32'h0);
    cmd(CMD_SPI_BYTE, b);
    cmd(CMD_SPI_DESELECT, 8'h00);
    check({31'h0, select_n}, 32'h1);
    check({24'h0, spi_rx}, {24'h0, b});
    chk_rd(REG_RX, {24'h0, a});
    wr(REG_CTRL, 32'h0);
    $display("test held select done");
  endtask
  task automatic t_i2c_wr(input logic [6:0] addr, input logic nk);
    wr(REG_CTRL, 32'h01);
    cmd(CMD_I2C_START, 8'h00);
    check({31'h0, i2c_act}, 32'h1);
    cmd(CMD_I2C_WRITE, {addr, 1'b0});
    chk_rd(REG_STAT, {29'h0, nk, 2'b00});
    if (!nk)
    begin
      cmd(CMD_I2C_WRITE, 8'hc3);
      check({24'h0, i2c_rx}, 32'hc3);
      chk_rd(REG_STAT, 32'h0);
    end
    cmd(CMD_I2C_STOP, 8'h00);
    check({31'h0, i2c_act}, 32'h0);
    check({30'h0, scl_line, sda_line}, 32'h3);
    wr(REG_STAT, 32'h1c);
    $display("test bus write %h done", addr);
  endtask
  task automatic t_i2c_rd;
    cmd(CMD_I2C_START, 8'h00);
    cmd(CMD_I2C_WRITE, {7'h2a, 1'b1});
    chk_rd(REG_STAT, 32'h0);
    cmd(CMD_I2C_READ_ACK, 8'h00);
    chk_rd(REG_RX, 32'ha5);
    cmd(CMD_I2C_READ_NACK, 8'h00);
    chk_rd(REG_RX, 32'ha5);
    cmd(CMD_I2C_START, 8'h00);
    check({31'h0, i2c_act}, 32'h1);
    cmd(CMD_I2C_STOP, 8'h00);
    check({31'h0, i2c_act}, 32'h0);
    $display("test bus read done");
  endtask
  initial
  begin
    #(25 * 30000);
    n_fail++;
    end_sim;
  end
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs;
    t_spi(8'h3c, 8'hc5, 1'b0);
    t_spi(8'h81, 8'h7e, 1'b1);
    t_keep(8'h69, 8'h12);
    t_i2c_wr(7'h2a, 1'b0);
    t_i2c_wr(7'h15, 1'b1);
    t_i2c_rd;
    end_sim;
  end
endmodule // spss_host_tb_top
